// file: ieb_pkg.sv
// package: register map, masks and constants for the interrupt enable bank
package ieb_pkg;
  localparam int unsigned IEB_REG_W = 16;
  localparam int unsigned IEB_NREG = 4;
  localparam int unsigned IEB_NSRC = IEB_NREG * IEB_REG_W;
  localparam int unsigned IEB_PRIO_W = 3;
  localparam int unsigned IEB_ADDR_W = 12;

  localparam logic [IEB_ADDR_W-1:0] INT_ENABLE_CTL_0_OFS = 12'h000;
  localparam logic [IEB_ADDR_W-1:0] INT_ENABLE_CTL_1_OFS = 12'h004;
  localparam logic [IEB_ADDR_W-1:0] INT_ENABLE_CTL_2_OFS = 12'h008;
  localparam logic [IEB_ADDR_W-1:0] INT_ENABLE_CTL_3_OFS = 12'h00c;
  localparam logic [IEB_ADDR_W-1:0] INT_FLAG_0_OFS = 12'h010;
  localparam logic [IEB_ADDR_W-1:0] INT_PEND_0_OFS = 12'h020;
  localparam logic [IEB_ADDR_W-1:0] INT_PRIO_0_OFS = 12'h040;
  localparam logic [IEB_ADDR_W-1:0] IEB_BANK_MASK = 12'hff0;
  localparam logic [IEB_ADDR_W-1:0] IEB_PRIO_MASK = 12'hfc0;

  // only bits 2..0 of ctl 0 are covered; ctl 0 bits above are held 0
  localparam logic [IEB_REG_W-1:0] IEB_IMPL_MASK_0 = 16'h0007;
  localparam logic [IEB_REG_W-1:0] IEB_IMPL_MASK_1 = 16'hffdf;
  localparam logic [IEB_REG_W-1:0] IEB_IMPL_MASK_2 = 16'h601f;
  localparam logic [IEB_REG_W-1:0] IEB_IMPL_MASK_3 = 16'h7800;
  localparam logic [IEB_REG_W-1:0] IEB_CAN_MASK_2 = 16'h000c;
  localparam logic [IEB_REG_W-1:0] IEB_EN_RESET = 16'h0000;
  localparam logic [IEB_PRIO_W-1:0] IEB_PRIO_RESET = 3'h4;
  localparam logic [IEB_PRIO_W-1:0] IEB_PRIO_OFF = 3'h0;

  // bit positions
  localparam int unsigned OUTCMP1_IRQ_EN_BIT = 2;
  localparam int unsigned INCAP1_IRQ_EN_BIT = 1;
  localparam int unsigned EXTIRQ0_EN_BIT = 0;
  localparam int unsigned CAN_EVENT_IRQ_EN_BIT = 3;
  localparam int unsigned CAN_RX_READY_IRQ_EN_BIT = 2;

  localparam logic [1:0] AXI_OKAY = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;
endpackage : ieb_pkg

// file: ieb_gate.sv
// per-source request gating and priority qualification
`timescale 1ns/1ps
module ieb_gate #(
  parameter int unsigned NSRC = ieb_pkg::IEB_NSRC,
  parameter int unsigned PW = ieb_pkg::IEB_PRIO_W
) (
  input wire logic [NSRC-1:0] flag,
  input wire logic [NSRC-1:0] enable,
  input wire logic [NSRC*PW-1:0] prio,
  output logic [NSRC-1:0] request
);
  import ieb_pkg::*;
  generate
    for (genvar i = 0; i < NSRC; i++) begin : g_src
      assign request[i] = flag[i] & enable[i] & (prio[i*PW +: PW] != IEB_PRIO_OFF);
    end
  endgenerate
endmodule : ieb_gate

// file: ieb_bank.sv
// top: interrupt enable bank with flags, priorities and AXI4-Lite slave
`timescale 1ns/1ps
module ieb_bank #(
  parameter bit HAS_CAN = 1'b1
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [ieb_pkg::IEB_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ieb_pkg::IEB_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [ieb_pkg::IEB_NSRC-1:0] irq_src,
  output logic [ieb_pkg::IEB_NSRC-1:0] irq_req
);
  import ieb_pkg::*;

  localparam logic [IEB_NSRC-1:0] IMPL = {IEB_IMPL_MASK_3, IEB_IMPL_MASK_2,
                                          IEB_IMPL_MASK_1, IEB_IMPL_MASK_0};
  localparam logic [IEB_NSRC-1:0] CAN_CUT = HAS_CAN ? '0 :
      {IEB_REG_W'(0), IEB_CAN_MASK_2, IEB_REG_W'(0), IEB_REG_W'(0)};
  localparam logic [IEB_NSRC-1:0] WMASK = IMPL & ~CAN_CUT;

  // map and priority packing are laid out for 64 sources of 3 bits
  if (IEB_NSRC != 64 || IEB_PRIO_W != 3) begin : g_bad_size
    $error("ieb_bank: unsupported source count or priority width");
  end

  logic [IEB_NSRC-1:0] enable;
  logic [IEB_NSRC-1:0] next_enable;
  logic [IEB_NSRC-1:0] flag;
  logic [IEB_NSRC-1:0] next_flag;
  logic [IEB_NSRC*IEB_PRIO_W-1:0] prio;
  logic [IEB_NSRC*IEB_PRIO_W-1:0] next_prio;
  logic [IEB_NSRC-1:0] srcMeta;
  logic [IEB_NSRC-1:0] srcSync;
  logic [IEB_NSRC-1:0] gated;

  logic awHeld;
  logic wHeld;
  logic [IEB_ADDR_W-1:0] awAddr;
  logic [31:0] wData;
  logic [3:0] wStrb;
  logic next_awHeld;
  logic next_wHeld;
  logic [IEB_ADDR_W-1:0] next_awAddr;
  logic [31:0] next_wData;
  logic [3:0] next_wStrb;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic next_arready;
  logic next_awready;
  logic next_wready;

  // source inputs come from other clocks: two-stage synchroniser
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      srcMeta <= '0;
      srcSync <= '0;
    end else begin
      srcMeta <= irq_src;
      srcSync <= srcMeta;
    end
  end

  ieb_gate #(.NSRC(IEB_NSRC), .PW(IEB_PRIO_W)) u_gate (
    .flag(flag),
    .enable(enable),
    .prio(prio),
    .request(gated)
  );

  function automatic logic [IEB_REG_W-1:0] merge16(input logic [IEB_REG_W-1:0] old,
                                                  input logic [31:0] d,
                                                  input logic [3:0] s,
                                                  input logic [IEB_REG_W-1:0] m);
    logic [IEB_REG_W-1:0] v;
    v = old;
    if (s[0]) begin
      v[7:0] = d[7:0];
    end
    if (s[1]) begin
      v[15:8] = d[15:8];
    end
    merge16 = v & m;
  endfunction : merge16

  logic doWrite;
  logic doRead;
  assign doWrite = awHeld && wHeld && !s_axi_bvalid;
  assign doRead = s_axi_arvalid && s_axi_arready;

  // write channel capture and register update
  always_comb begin
    logic [1:0] idx;
    logic hit;
    logic [IEB_REG_W-1:0] cur;
    logic [IEB_REG_W-1:0] m;
    idx = awAddr[3:2];
    hit = 1'b0;
    cur = '0;
    m = '0;
    next_awHeld = awHeld;
    next_wHeld = wHeld;
    next_awAddr = awAddr;
    next_wData = wData;
    next_wStrb = wStrb;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_enable = enable;
    next_prio = prio;
    // flags: set from source wins over software clear
    next_flag = flag;
    if (s_axi_awvalid && s_axi_awready) begin
      next_awHeld = 1'b1;
      next_awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_wHeld = 1'b1;
      next_wData = s_axi_wdata;
      next_wStrb = s_axi_wstrb;
    end
    if (doWrite) begin
      next_awHeld = 1'b0;
      next_wHeld = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = AXI_OKAY;
      if ((awAddr & IEB_BANK_MASK) == INT_ENABLE_CTL_0_OFS) begin
        cur = enable[idx*IEB_REG_W +: IEB_REG_W];
        m = WMASK[idx*IEB_REG_W +: IEB_REG_W];
        next_enable[idx*IEB_REG_W +: IEB_REG_W] = merge16(cur, wData, wStrb, m);
        hit = 1'b1;
      end else if ((awAddr & IEB_BANK_MASK) == INT_FLAG_0_OFS) begin
        cur = flag[idx*IEB_REG_W +: IEB_REG_W];
        m = IMPL[idx*IEB_REG_W +: IEB_REG_W];
        next_flag[idx*IEB_REG_W +: IEB_REG_W] = merge16(cur, wData, wStrb, m);
        hit = 1'b1;
      end else if ((awAddr & IEB_PRIO_MASK) == INT_PRIO_0_OFS) begin
        // one word holds four 3-bit fields at nibble spacing
        for (int k = 0; k < 4; k++) begin
          if (wStrb[k/2]) begin
            next_prio[(awAddr[5:2]*4 + k)*IEB_PRIO_W +: IEB_PRIO_W] = wData[k*4 +: IEB_PRIO_W];
          end
        end
        hit = 1'b1;
      end
      if (!hit) begin
        next_bresp = AXI_SLVERR;
      end
    end else if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    next_flag = next_flag | (srcSync & IMPL);
    next_awready = !next_awHeld && !next_bvalid;
    next_wready = !next_wHeld && !next_bvalid;
  end

  // read channel
  always_comb begin
    logic [1:0] idx;
    idx = s_axi_araddr[3:2];
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    next_arready = s_axi_arready;
    // idle after reset: open the address channel
    if (!s_axi_arready && !s_axi_rvalid) begin
      next_arready = 1'b1;
    end
    if (doRead) begin
      next_rvalid = 1'b1;
      next_arready = 1'b0;
      next_rresp = AXI_OKAY;
      next_rdata = '0;
      if ((s_axi_araddr & IEB_BANK_MASK) == INT_ENABLE_CTL_0_OFS) begin
        next_rdata[IEB_REG_W-1:0] = enable[idx*IEB_REG_W +: IEB_REG_W];
      end else if ((s_axi_araddr & IEB_BANK_MASK) == INT_FLAG_0_OFS) begin
        next_rdata[IEB_REG_W-1:0] = flag[idx*IEB_REG_W +: IEB_REG_W];
      end else if ((s_axi_araddr & IEB_BANK_MASK) == INT_PEND_0_OFS) begin
        next_rdata[IEB_REG_W-1:0] = irq_req[idx*IEB_REG_W +: IEB_REG_W];
      end else if ((s_axi_araddr & IEB_PRIO_MASK) == INT_PRIO_0_OFS) begin
        for (int k = 0; k < 4; k++) begin
          next_rdata[k*4 +: IEB_PRIO_W] =
            prio[(s_axi_araddr[5:2]*4 + k)*IEB_PRIO_W +: IEB_PRIO_W];
        end
      end else begin
        next_rresp = AXI_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
      next_arready = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      enable <= {IEB_NREG{IEB_EN_RESET}};
      flag <= '0;
      prio <= {IEB_NSRC{IEB_PRIO_RESET}};
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= '0;
      wData <= '0;
      wStrb <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= AXI_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= AXI_OKAY;
      irq_req <= '0;
    end else begin
      enable <= next_enable & WMASK;
      flag <= next_flag;
      prio <= next_prio;
      awHeld <= next_awHeld;
      wHeld <= next_wHeld;
      awAddr <= next_awAddr;
      wData <= next_wData;
      wStrb <= next_wStrb;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
      irq_req <= gated;
    end
  end
endmodule : ieb_bank

// file: ieb_src_model.sv
// model of the peripheral request sources
`timescale 1ns/1ps
module ieb_src_model (
  input wire logic core_clk,
  input wire logic [ieb_pkg::IEB_NSRC-1:0] want,
  output logic [ieb_pkg::IEB_NSRC-1:0] irq_src
);
  import ieb_pkg::*;
  initial irq_src = '0;
  // level requests, launched just after the edge
  always @(posedge core_clk) begin
    irq_src <= want;
  end
endmodule : ieb_src_model

// file: ieb_bank_monitor.sv
// port checker for the interrupt enable bank
`timescale 1ns/1ps
module ieb_bank_monitor #(
  parameter bit HAS_CAN = 1'b1
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [ieb_pkg::IEB_NSRC-1:0] irq_req
);
  import ieb_pkg::*;
  localparam logic [63:0] LIVE = {16'h7800, 16'h601f, 16'hffdf, 16'h0007};
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  chk_dead_bits: assert property ((irq_req & ~LIVE) == 64'h0)
    else $error("request on unimplemented bit");
  chk_can_off: assert property (!HAS_CAN |-> irq_req[35:34] == 2'b00)
    else $error("can request without can");
  chk_rd_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_rd_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  chk_err_zero: assert property (s_axi_rvalid && s_axi_rresp == AXI_SLVERR
    |-> s_axi_rdata == 32'h0) else $error("error read with data");
  chk_wr_answer: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
  chk_rdy_back: assert property (s_axi_bvalid && s_axi_bready
    |=> s_axi_awready && s_axi_wready && !s_axi_bvalid) else $error("write side not ready");
  chk_ar_back: assert property (s_axi_rvalid && s_axi_rready
    |=> s_axi_arready && !s_axi_rvalid) else $error("read side not ready");
endmodule : ieb_bank_monitor

bind ieb_bank ieb_bank_monitor #(.HAS_CAN(HAS_CAN)) u_mon (
  .core_clk(core_clk), .rst_n(rst_n), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq_req(irq_req));

// file: ieb_bank_tb.sv
// self-checking bench for the interrupt enable bank
`timescale 1ns/1ps
module ieb_bank_tb;
  import ieb_pkg::*;
  localparam bit CAN = 1'b0;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic [11:0] s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [63:0] want = 64'h0;
  logic [63:0] irqSrc, irqReq;
  int nErrors = 0;
  int checkCount = 0;
  int cycles = 0;
  always #5 core_clk = ~core_clk;
  ieb_src_model srcs (.core_clk(core_clk), .want(want), .irq_src(irqSrc));
  ieb_bank #(.HAS_CAN(CAN)) dut (.core_clk(core_clk), .rst_n(rst_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'h3), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(1'b1), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(1'b1), .irq_src(irqSrc), .irq_req(irqReq));

  task automatic finalReport;
    $display("errors %0d checks %0d", nErrors, checkCount);
    if (nErrors == 0 && checkCount > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finalReport

  task automatic cmp(input string what, input logic [63:0] exp, input logic [63:0] got);
    checkCount++;
    if (got !== exp) begin
      nErrors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  task automatic wrCheck(input logic [11:0] a, input logic [15:0] d, input logic [1:0] e);
    bit aw = 1'b0;
    bit w = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw && w)) begin
      @(posedge core_clk);
      aw = aw || s_axi_awready === 1'b1;
      w = w || s_axi_wready === 1'b1;
      s_axi_awvalid <= !aw;
      s_axi_wvalid <= !w;
    end
    do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
    cmp("bresp", {62'h0, e}, {62'h0, s_axi_bresp});
  endtask : wrCheck

  task automatic rdCheck(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge core_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
    cmp("rdata", {32'h0, e}, {32'h0, s_axi_rdata});
    cmp("rresp", {62'h0, er}, {62'h0, s_axi_rresp});
  endtask : rdCheck

  // reset value, all ones and all zeros on every enable register
  task automatic checkAccess;
    logic [15:0] live [4] = '{16'h0007, 16'hffdf, 16'h6013, 16'h7800};
    for (int i = 0; i < 4; i++) begin
      rdCheck(12'(i * 4), 32'h0, AXI_OKAY);
      wrCheck(12'(i * 4), 16'hffff, AXI_OKAY);
      rdCheck(12'(i * 4), {16'h0, live[i]}, AXI_OKAY);
      wrCheck(12'(i * 4), 16'h0000, AXI_OKAY);
      rdCheck(12'(i * 4), 32'h0, AXI_OKAY);
    end
  endtask : checkAccess

  task automatic checkUnmapped;
    wrCheck(12'h100, 16'hffff, AXI_SLVERR);
    rdCheck(12'h100, 32'h0, AXI_SLVERR);
  endtask : checkUnmapped

  // sources 0 and 31 through enable, source 31 through priority; the two can sources stay cut with can off
  task automatic checkGate;
    want <= 64'h0000_000c_8000_0001;
    repeat (8) @(posedge core_clk);
    cmp("req masked", 64'h0, irqReq);
    wrCheck(12'h000, 16'h0001, AXI_OKAY);
    wrCheck(12'h004, 16'h8000, AXI_OKAY);
    wrCheck(12'h008, 16'h000c, AXI_OKAY);
    repeat (3) @(posedge core_clk);
    cmp("req enabled", 64'h8000_0001, irqReq);
    rdCheck(12'h018, 32'h000c, AXI_OKAY);
    rdCheck(12'h020, 32'h0001, AXI_OKAY);
    rdCheck(12'h024, 32'h8000, AXI_OKAY);
    wrCheck(12'h05c, 16'h0000, AXI_OKAY);
    repeat (3) @(posedge core_clk);
    cmp("req prio off", 64'h1, irqReq);
    wrCheck(12'h05c, 16'h7000, AXI_OKAY);
    repeat (3) @(posedge core_clk);
    cmp("req prio 7", 64'h8000_0001, irqReq);
    wrCheck(12'h000, 16'h0000, AXI_OKAY);
    repeat (3) @(posedge core_clk);
    cmp("req disabled", 64'h8000_0000, irqReq);
  endtask : checkGate

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      nErrors++;
      finalReport();
    end
  end

  initial begin
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    checkAccess();
    checkUnmapped();
    checkGate();
    finalReport();
  end
endmodule : ieb_bank_tb
